// ===== design/raiec_pkg.sv
// package: constants, types and vector helpers of the exception controller
package raiec_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register port geometry and map
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;     // edge select, wdog options
    localparam logic [7:0] REG_SENSE = 8'h01;    // 1 = falling edge, 0 = level
    localparam logic [7:0] REG_ENABLE = 8'h02;   // per-source enables a,b,c,kp
    localparam logic [7:0] REG_KEYMASK = 8'h03;  // key_line_mask_reg, 1 = masked
    localparam logic [7:0] REG_STATUS = 8'h04;   // read only state

    // field positions
    localparam int CTRL_EDGE_BIT = 0;   // unmaskable_edge_select
    localparam int CTRL_WDRST_BIT = 1;  // watchdog overflow resets the chip
    localparam int CTRL_WDNMI_BIT = 2;  // watchdog overflow raises the nmi
    localparam int ST_PEND_LSB = 0;     // status [4:0] pending kp,c,b,a,nmi
    localparam int ST_ARMED_BIT = 5;    // unmaskable input accepted
    localparam int ST_EXTRST_BIT = 6;   // last reset came from the pin

    // reset values
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [3:0] SENSE_RST = 4'h0;
    localparam logic [3:0] ENABLE_RST = 4'h0;
    localparam logic [7:0] KEYMASK_RST = 8'hFF;

    // timing
    localparam logic [9:0] WDOG_RST_CYCLES = 10'h206;  // 518 clocks

    // vector numbers and addresses
    localparam logic [7:0] VEC_RESET = 8'h00;
    localparam logic [7:0] VEC_NMI = 8'h03;
    localparam logic [7:0] VEC_A = 8'h04;
    localparam logic [7:0] VEC_B = 8'h05;
    localparam logic [7:0] VEC_C = 8'h06;
    localparam logic [7:0] VEC_KEYPAD = 8'h0A;
    localparam logic [7:0] VEC_INT_LO = 8'h11;  // first block starts at 17
    localparam logic [7:0] VEC_INT_HI = 8'h2C;  // second block starts at 44
    localparam int INT_LO_COUNT = 20;
    localparam int N_INT = 26;
    localparam int WDOG_IDX = 20;               // internal slot of wdog ovf
    localparam logic [15:0] RESET_VEC_ADDR = 16'h0000;
    localparam logic [3:0][7:0] EXT_VEC = {VEC_KEYPAD, VEC_C, VEC_B, VEC_A};

    ////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [2:0] {ST_HOLD, ST_SET_MASK, ST_INIT, ST_FETCH,
        ST_RUN} raiec_state_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } raiec_bus_s;

    typedef struct packed {
        logic valid;       // one-cycle request to the core
        logic is_reset;    // reset vector fetch rather than interrupt
        logic [7:0] vec_no;
        logic [15:0] vec_addr;
    } raiec_exc_s;

    // vector number of an internal source slot
    function automatic logic [7:0] raiec_int_vec(input int idx);
        if (idx < INT_LO_COUNT)
            return VEC_INT_LO + 8'(idx);
        return VEC_INT_HI + 8'(idx - INT_LO_COUNT);
    endfunction : raiec_int_vec

endpackage : raiec_pkg

// ===== design/raiec_top.sv
// exception controller: reset sequencing and interrupt arbitration
//
// Functional notes
// - reset always preempts interrupt handling
// - pin low holds reset, rise starts sequence
// - interrupts taken only at boundaries
// - no detection after condition-register instructions
// - reset halts and initializes supporting registers
// - leave reset by pin rise or pulse end
// - watchdog reset lasts exactly 518 clocks
// - sequence first sets the global mask
// - then init registers, then fetch vector zero
// - all interrupts blocked right after reset
// - nmi enabled after first instruction completes
// - condition instruction first delays nmi enabling
// - five external and 26 internal sources
// - global mask blocks all but nmi
// - per-source falling edge or level sense
// - nmi is edge sensed, edge selectable
// - each source has its own vector
// - keypad request from eight maskable key lines
// - watchdog overflow gives nmi or overflow irq
// - edge select 0 falling (reset), 1 rising
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
// two-flop synchroniser for asynchronous pins
module raiec_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '1
) (
    input logic clk,
    input logic resetn,
    input logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;  // first stage, read only by q

    // plain double flop; idle level of the pins is high
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_r <= INIT;
            q <= INIT;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : raiec_sync

////////////////////////////////////////////////////////////////////////////
module raiec_top (
    input logic clk,
    input logic resetn,
    input raiec_pkg::raiec_bus_s bus,
    output logic [raiec_pkg::DATA_W-1:0] rdata,
    input logic chip_init_pin,
    input logic unmaskable_pin,
    input logic ext_request_a,
    input logic ext_request_b,
    input logic ext_request_c,
    input logic [7:0] key_lines,
    input logic [raiec_pkg::N_INT-1:0] periph_req,
    input logic wdog_overflow,
    input logic instr_done,
    input logic cond_instr,
    input logic seq_done,
    input logic cpu_mask_flag,
    output logic core_reset,
    output logic set_mask,
    output logic periph_init,
    output raiec_pkg::raiec_exc_s exc_req
);
    import raiec_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // synchronised pins
    logic [12:0] pins_s;       // init, nmi, a, b, c, keys
    logic init_s;              // chip_init_pin after two flops
    logic nmi_s;               // unmaskable_pin after two flops
    logic [2:0] ext_s;         // ext_request_c..a after two flops
    logic [7:0] keys_s;        // key_lines after two flops

    raiec_sync #(.W(13), .INIT(13'h1FFF)) u_sync (
        .clk(clk),
        .resetn(resetn),
        .d({key_lines, ext_request_c, ext_request_b, ext_request_a,
            unmaskable_pin, chip_init_pin}),
        .q(pins_s)
    );

    assign init_s = pins_s[0];
    assign nmi_s = pins_s[1];
    assign ext_s = pins_s[4:2];
    assign keys_s = pins_s[12:5];

    ////////////////////////////////////////////////////////////////////////
    // declarations
    raiec_state_e state_r;     // reset sequencer state
    raiec_state_e state_nxt;
    logic hold;                // reset state wanted this cycle
    logic wd_start;            // watchdog overflow with reset option
    logic [9:0] wd_cnt_r;      // remaining watchdog reset clocks
    logic extrst_r;            // last reset came from the pin
    logic [2:0] ctrl_r;        // edge select and watchdog options
    logic [3:0] sense_r;       // 1 = falling edge sensed
    logic [3:0] enable_r;      // per-source enables
    logic [7:0] keymask_r;     // key line masks
    logic nmi_armed_r;         // first instruction has completed
    logic nmi_d_r;             // previous nmi level for edge detect
    logic nmi_edge;            // selected edge seen on the nmi input
    logic nmi_set;             // nmi event from pin or watchdog
    logic nmi_pend_r;          // sticky nmi request
    logic wd_ovf_set;          // watchdog overflow routed as ordinary irq
    logic wd_ovf_pend_r;       // sticky watchdog overflow request
    logic [3:0] ext_act;       // active-high request levels kp,c,b,a
    logic [3:0] ext_prev_r;    // last cycle's request levels
    logic [3:0] ext_edge;      // new assertion (falling pin edge)
    logic [3:0] edge_pend_r;   // sticky edge-sensed requests
    logic [3:0] ext_pend;      // edge or level request per source
    logic [3:0] ext_elig;      // enabled external requests
    logic [N_INT-1:0] int_req; // internal requests with wdog slot merged
    logic boundary;            // detection point this cycle
    logic accept_ok;           // an interrupt may be taken now
    logic take;                // an interrupt is taken
    logic found;               // arbitration already picked a source
    logic [7:0] take_no;       // vector number taken
    logic clr_nmi;
    logic clr_wd;
    logic [3:0] clr_ext;

    ////////////////////////////////////////////////////////////////////////
    // reset entry: pin low or watchdog pulse; reset beats everything
    assign wd_start = wdog_overflow & ctrl_r[CTRL_WDRST_BIT]
        & (state_r == ST_RUN);
    // pin low or pulse running keeps the chip in reset
    assign hold = ~init_s | (wd_cnt_r != 10'h000);

    // watchdog pulse counter, loaded on overflow, counts down to zero
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            wd_cnt_r <= 10'h000;
        else if (wd_start)
            wd_cnt_r <= WDOG_RST_CYCLES;
        else if (wd_cnt_r != 10'h000)
            wd_cnt_r <= wd_cnt_r - 10'h001;
    end

    // reset source flag survives the reset it describes
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            extrst_r <= 1'b1;
        else if (!init_s)
            extrst_r <= 1'b1;
        else if (wd_start)
            extrst_r <= 1'b0;
    end

    // sequencer: hold, set mask, init registers, fetch vector, run
    always_comb
    begin
        if (hold)
            state_nxt = ST_HOLD;
        else
        begin
            case (state_r)
                ST_HOLD: state_nxt = ST_SET_MASK;
                ST_SET_MASK: state_nxt = ST_INIT;
                ST_INIT: state_nxt = ST_FETCH;
                ST_FETCH: state_nxt = ST_RUN;
                ST_RUN: state_nxt = ST_RUN;
                default: state_nxt = ST_HOLD;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            state_r <= ST_HOLD;
        else
            state_r <= state_nxt;
    end

    // sequence strobes are registered off the next state so they line up
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            core_reset <= 1'b1;
            set_mask <= 1'b0;
            periph_init <= 1'b0;
        end
        else
        begin
            core_reset <= hold;
            set_mask <= (state_nxt == ST_SET_MASK);
            periph_init <= (state_nxt == ST_INIT);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register port; registers return to reset values while held
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_r <= CTRL_RST;
            sense_r <= SENSE_RST;
            enable_r <= ENABLE_RST;
            keymask_r <= KEYMASK_RST;
        end
        else if (hold)
        begin
            // supporting registers are initialized by any reset
            ctrl_r <= CTRL_RST;
            sense_r <= SENSE_RST;
            enable_r <= ENABLE_RST;
            keymask_r <= KEYMASK_RST;
        end
        else if (bus.wr)
        begin
            case (bus.addr)
                REG_CTRL: ctrl_r <= bus.wdata[2:0];
                REG_SENSE: sense_r <= bus.wdata[3:0];
                REG_ENABLE: enable_r <= bus.wdata[3:0];
                REG_KEYMASK: keymask_r <= bus.wdata;
                default: ;  // unmapped and status writes are dropped
            endcase
        end
    end

    // read data stand for the single cycle after the strobe
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rdata <= 8'h00;
        else if (bus.rd)
        begin
            case (bus.addr)
                REG_CTRL: rdata <= {5'h00, ctrl_r};
                REG_SENSE: rdata <= {4'h0, sense_r};
                REG_ENABLE: rdata <= {4'h0, enable_r};
                REG_KEYMASK: rdata <= keymask_r;
                REG_STATUS: rdata <= {1'b0, extrst_r, nmi_armed_r,
                    ext_pend[3], ext_pend[2:0], nmi_pend_r};
                default: rdata <= 8'h00;  // unmapped reads as zero
            endcase
        end
        else
            rdata <= 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // nmi edge detection and watchdog routing
    assign nmi_edge = ctrl_r[CTRL_EDGE_BIT] ? (nmi_s & ~nmi_d_r)
        : (~nmi_s & nmi_d_r);
    // overflow without reset option becomes nmi or ordinary irq
    assign nmi_set = nmi_edge | (wdog_overflow & ~ctrl_r[CTRL_WDRST_BIT]
        & ctrl_r[CTRL_WDNMI_BIT]);
    assign wd_ovf_set = wdog_overflow & ~ctrl_r[CTRL_WDRST_BIT]
        & ~ctrl_r[CTRL_WDNMI_BIT];

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            nmi_d_r <= 1'b1;
        else
            nmi_d_r <= nmi_s;
    end

    // sticky requests; a new event in the clearing cycle wins
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            nmi_pend_r <= 1'b0;
            wd_ovf_pend_r <= 1'b0;
        end
        else if (hold)
        begin
            nmi_pend_r <= 1'b0;
            wd_ovf_pend_r <= 1'b0;
        end
        else
        begin
            nmi_pend_r <= (nmi_pend_r & ~clr_nmi) | nmi_set;
            wd_ovf_pend_r <= (wd_ovf_pend_r & ~clr_wd) | wd_ovf_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // external lines: a, b, c and the keypad merge, active low
    // keypad request is any unmasked key line pulled low
    assign ext_act = {|(~keys_s & ~keymask_r), ~ext_s};
    assign ext_edge = ext_act & ~ext_prev_r;
    // edge sources use the sticky flag, level sources the live line
    assign ext_pend = (edge_pend_r & sense_r)
        | (ext_act & ~sense_r);
    assign ext_elig = ext_pend & enable_r;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ext_prev_r <= 4'h0;
            edge_pend_r <= 4'h0;
        end
        else if (hold)
        begin
            ext_prev_r <= 4'h0;
            edge_pend_r <= 4'h0;
        end
        else
        begin
            ext_prev_r <= ext_act;
            edge_pend_r <= (edge_pend_r & ~clr_ext)
                | (ext_edge & sense_r);
        end
    end

    // internal sources, with the overflow flag in the watchdog slot
    always_comb
    begin
        int_req = periph_req;
        int_req[WDOG_IDX] = wd_ovf_pend_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // post-reset arming: the first instruction always runs
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            nmi_armed_r <= 1'b0;
        else if (state_nxt != ST_RUN)
            nmi_armed_r <= 1'b0;
        else if (instr_done && !cond_instr)
            nmi_armed_r <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // arbitration at instruction or sequence boundaries
    assign boundary = seq_done | (instr_done & ~cond_instr);
    assign accept_ok = boundary & ~hold & (state_r == ST_RUN)
        & nmi_armed_r;

    // fixed priority: nmi, a, b, c, keypad, internals in slot order
    always_comb
    begin
        found = 1'b0;
        take_no = VEC_NMI;
        clr_nmi = 1'b0;
        clr_wd = 1'b0;
        clr_ext = 4'h0;
        if (accept_ok && nmi_pend_r)
        begin
            found = 1'b1;
            clr_nmi = 1'b1;
        end
        else if (accept_ok && !cpu_mask_flag)
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (!found && ext_elig[i])
                begin
                    found = 1'b1;
                    take_no = EXT_VEC[i];
                    clr_ext[i] = 1'b1;
                end
            end
            for (int j = 0; j < N_INT; j++)
            begin
                if (!found && int_req[j])
                begin
                    found = 1'b1;
                    take_no = raiec_int_vec(j);
                    clr_wd = (j == WDOG_IDX);
                end
            end
        end
        take = found;
    end

    // request to the core: reset fetch or the chosen vector
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            exc_req <= '0;
        else if (state_nxt == ST_FETCH)
        begin
            exc_req.valid <= 1'b1;
            exc_req.is_reset <= 1'b1;
            exc_req.vec_no <= VEC_RESET;
            exc_req.vec_addr <= RESET_VEC_ADDR;
        end
        else if (take)
        begin
            exc_req.valid <= 1'b1;
            exc_req.is_reset <= 1'b0;
            exc_req.vec_no <= take_no;
            exc_req.vec_addr <= {7'h00, take_no, 1'b0};
        end
        else
            exc_req <= '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence reset_steps_q;
        set_mask ##1 periph_init ##1
            (exc_req.valid && exc_req.is_reset
            && exc_req.vec_addr == RESET_VEC_ADDR);
    endsequence

    // the pulse is checked as a load plus single steps, since a
    // 518-cycle delay would be far too long for the property engine
    sequence wd_load_q;
        wd_cnt_r == WDOG_RST_CYCLES;
    endsequence

    sequence wd_step_q;
        wd_cnt_r == $past(wd_cnt_r) - 10'h001;
    endsequence

    reset_preempt_a: assert property (
        core_reset |-> !exc_req.valid)
        else $error("request issued while chip held in reset");

    pin_holds_a: assert property (
        !init_s |=> core_reset ##1 (core_reset || set_mask))
        else $error("low reset pin did not hold the chip");

    reset_order_a: assert property (
        $fell(core_reset) |-> reset_steps_q)
        else $error("reset sequence out of order");

    wdog_width_a: assert property (
        wd_start |=> wd_load_q)
        else $error("watchdog reset pulse width wrong");

    wdog_count_a: assert property (
        wd_cnt_r != 10'h000 |=> wd_step_q)
        else $error("watchdog pulse counter skipped a step");

    wdog_hold_a: assert property (
        wd_cnt_r != 10'h000 |=> core_reset)
        else $error("watchdog pulse did not hold the chip");

    boundary_only_a: assert property (
        exc_req.valid && !exc_req.is_reset |-> $past(boundary))
        else $error("interrupt taken off a boundary");

    cond_skip_a: assert property (
        instr_done && cond_instr && !seq_done |=> !exc_req.valid)
        else $error("interrupt taken after condition instruction");

    first_instr_a: assert property (
        !nmi_armed_r |=> !(exc_req.valid && !exc_req.is_reset))
        else $error("interrupt taken before first instruction");

    mask_gate_a: assert property (
        exc_req.valid && !exc_req.is_reset && exc_req.vec_no != VEC_NMI
        |-> !$past(cpu_mask_flag))
        else $error("masked interrupt accepted");

    nmi_catch_a: assert property (
        nmi_edge && !hold |=> nmi_pend_r || $past(clr_nmi))
        else $error("nmi edge not recorded");

endmodule : raiec_top

// ===== bench/raiec_cpu_model.sv
// cpu core stand-in: boundaries, exception sequences, mask flag
`timescale 1ns/100ps
module raiec_cpu_model (
    input logic clk,
    input logic resetn,
    input logic step,
    input logic cond,
    input logic clr_mask,
    input logic set_mask,
    input logic exc_valid,
    output logic instr_done,
    output logic cond_instr,
    output logic seq_done,
    output logic cpu_mask_flag
);
    logic [2:0] seq_cnt_r; // cycles left in a running sequence
    // one instruction ends the cycle after each step request
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
            {instr_done, cond_instr} <= 2'b00;
        else
            {instr_done, cond_instr} <= {step, step & cond};
    // a sequence lasts four cycles, so late requests meet its end
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
            seq_cnt_r <= 3'h0;
        else if (exc_valid)
            seq_cnt_r <= 3'h4;
        else if (seq_cnt_r != 3'h0)
            seq_cnt_r <= seq_cnt_r - 3'h1;
    assign seq_done = (seq_cnt_r == 3'h1);
    // entry to any exception masks; only software unmasks
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
            cpu_mask_flag <= 1'b1;
        else if (set_mask | exc_valid)
            cpu_mask_flag <= 1'b1;
        else if (clr_mask)
            cpu_mask_flag <= 1'b0;
endmodule : raiec_cpu_model

// ===== bench/testbench.sv
// testbench: scenarios and scoreboard for the exception controller
`timescale 1ns/100ps
module testbench;
    import raiec_pkg::*;
    logic clk = 0, resetn = 0, chip_init_pin = 1, unmaskable_pin = 1;
    logic ext_request_a = 1, ext_request_b = 1, ext_request_c = 1;
    logic wdog_overflow = 0, step = 0, cond = 0, clr_mask = 0;
    logic [7:0] key_lines = 8'hFF, rdata;
    logic [N_INT-1:0] periph_req = '0;
    raiec_bus_s bus = '0;
    raiec_exc_s exc_req;
    logic instr_done, cond_instr, seq_done, cpu_mask_flag;
    logic core_reset, set_mask, periph_init, rd_seen = 0, pm = 0;
    logic [24:0] xq[$], e; // notes: {is_reset, vec_no, vec_addr}
    logic [7:0] rq[$];
    int miscompares = 0, compares = 0, cyc = 0, n, i;
    raiec_top raiec_top_inst (.clk, .resetn, .bus, .rdata, .chip_init_pin,
        .unmaskable_pin, .ext_request_a, .ext_request_b, .ext_request_c,
        .key_lines, .periph_req, .wdog_overflow, .instr_done, .cond_instr,
        .seq_done, .cpu_mask_flag, .core_reset, .set_mask, .periph_init,
        .exc_req);
    raiec_cpu_model raiec_cpu_model_inst (.clk, .resetn, .step, .cond,
        .clr_mask, .set_mask, .exc_valid(exc_req.valid), .instr_done,
        .cond_instr, .seq_done, .cpu_mask_flag);
    always #5 clk = ~clk;
    task automatic chk(string what, logic [24:0] seen, logic [24:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic results();
        chk("leftover_notes", xq.size(), 0);
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results
    // hang guard: the run needs about 800 cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            miscompares++;
            results();
        end
    end
    // watcher: every result takes the oldest note; none spare allowed
    always @(posedge clk)
    begin
        if (exc_req.valid)
        begin
            e = xq.size() ? xq.pop_front() : 'x;
            chk("exception", exc_req[24:0], e);
        end
        if (rd_seen)
            chk("rdata", rdata, rq.pop_front());
        if (periph_init)
            chk("init_after_mask", pm, 1);
        rd_seen = bus.rd;
        pm = set_mask;
    end
    task automatic tick(int k);
        repeat (k) @(posedge clk);
    endtask : tick
    task automatic wr(logic [7:0] a, logic [7:0] d);
        bus <= {1'b1, 1'b0, a, d};
        tick(1);
        bus <= '0;
        tick(1);
    endtask : wr
    task automatic rd(logic [7:0] a, logic [7:0] d);
        rq.push_back(d);
        bus <= {1'b0, 1'b1, a, 8'h00};
        tick(1);
        bus <= '0;
        tick(2);
    endtask : rd
    task automatic ex(logic [7:0] v);
        xq.push_back({1'b0, v, 7'h00, v, 1'b0});
    endtask : ex
    // optional unmask, then one instruction and room for its sequence
    task automatic instr(logic c, logic k);
        clr_mask <= k;
        tick(1);
        {clr_mask, step, cond} <= {1'b0, 1'b1, c};
        tick(1);
        step <= 1'b0;
        tick(8);
    endtask : instr
    initial
    begin
        void'($urandom(32'hd699_a75d));
        xq.push_back({1'b1, 24'h00_0000});
        tick(3);
        // power-on low of the pin is stood in for by resetn; the full
        // 20 ms would blow the cycle budget of this run
        resetn <= 1'b1;
        tick(10);
        unmaskable_pin <= 1'b0;
        tick(6);
        instr(1, 0);
        instr(0, 0);
        rd(REG_STATUS, 8'h61); // pin reset flag, armed, nmi pending
        ex(VEC_NMI);
        instr(0, 0);
        wr(REG_ENABLE, 8'h0F);
        wr(REG_SENSE, 8'h05);
        {ext_request_a, ext_request_c} <= 2'b00;
        tick(6);
        instr(0, 0);
        instr(1, 1);
        ex(VEC_A);
        instr(0, 0);
        ex(VEC_C);
        instr(0, 1);
        {ext_request_a, ext_request_c, ext_request_b} <= 3'b110;
        tick(6);
        ex(VEC_B);
        instr(0, 1);
        ex(VEC_B);
        instr(0, 1);
        ext_request_b <= 1'b1;
        tick(6);
        instr(0, 1);
        wr(REG_KEYMASK, 8'hFE);
        n = 1 + $urandom % 7;
        key_lines <= ~(8'h01 << n);
        tick(6);
        instr(0, 1);
        key_lines[0] <= 1'b0;
        ex(VEC_KEYPAD);
        tick(6);
        instr(0, 0);
        key_lines <= 8'hFF;
        i = $urandom % 26;
        i = (i == WDOG_IDX) ? 0 : i;
        periph_req[i] <= 1'b1;
        ex(8'(i < 20 ? 17 + i : 24 + i));
        instr(0, 1);
        periph_req <= '0;
        wr(REG_CTRL, 8'h01);
        unmaskable_pin <= 1'b1;
        ex(VEC_NMI);
        tick(6);
        instr(0, 0);
        for (n = 0; n < 2; n++)
        begin
            wr(REG_CTRL, n ? 8'h00 : 8'h04);
            wdog_overflow <= 1'b1;
            tick(1);
            wdog_overflow <= 1'b0;
            ex(n ? VEC_INT_HI : VEC_NMI);
            instr(0, n[0]);
        end
        wr(REG_CTRL, 8'h02);
        xq.push_back({1'b1, 24'h00_0000});
        wdog_overflow <= 1'b1;
        tick(1);
        wdog_overflow <= 1'b0;
        n = 0;
        repeat (10) if (!core_reset) tick(1);
        while (core_reset && n < 600)
        begin
            tick(1);
            n++;
        end
        chk("wdog_reset_len", n, 518);
        tick(10);
        rd(REG_STATUS, 8'h00);
        wr(REG_KEYMASK, 8'h00);
        xq.push_back({1'b1, 24'h00_0000});
        chip_init_pin <= 1'b0;
        tick(10);
        chk("core_reset", core_reset, 1);
        chip_init_pin <= 1'b1;
        tick(10);
        rd(REG_STATUS, 8'h40);
        rd(REG_KEYMASK, 8'hFF);
        rd(8'h10, 8'h00);
        tick(5);
        results();
    end
endmodule : testbench
